// [urfe_pkg.sv]
// shared constants and types for the serial receive front end
package urfe_pkg;

  // ----------------------------------------------------------------
  // oversampling ratios, in sampling ticks per bit
  // ----------------------------------------------------------------
  localparam logic [4:0] OVS_16 = 5'h10;
  localparam logic [4:0] OVS_8 = 5'h08;

  // ----------------------------------------------------------------
  // character format
  // ----------------------------------------------------------------
  localparam int CHAR_W = 9; // widest character, nine-bit mode
  localparam logic [3:0] CHAR_BASE = 4'h5; // length code 0 means 5 bits
  localparam logic [3:0] NINE_LEN = 4'h9;

  // parity type field codes
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_MD_DATA = 3'h6; // multidrop
  localparam logic [2:0] PAR_MD_ADDR = 3'h7; // multidrop
  localparam logic [1:0] PAR_NONE_HI = 2'h2; // codes 4 and 5: no parity

  // ----------------------------------------------------------------
  // manchester preamble patterns and sync delimiters
  // ----------------------------------------------------------------
  localparam logic [1:0] PP_ALL_ONE = 2'h0;
  localparam logic [1:0] PP_ALL_ZERO = 2'h1;
  localparam logic [1:0] PP_ONE_ZERO = 2'h2;
  localparam logic [1:0] PP_ZERO_ONE = 2'h3;
  // half-bit samples, oldest first in the top bit
  localparam logic [5:0] SYNC_CMD = 6'h38; // high 1.5 bits, then low
  localparam logic [5:0] SYNC_DATA = 6'h07; // low 1.5 bits, then high
  localparam logic [2:0] SYNC_LAST_HALF = 3'h5; // sixth half-bit sample

  // ----------------------------------------------------------------
  // receiver states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, // hunting for a start
    ST_PRE = 4'h2, // manchester preamble
    ST_SFD = 4'h4, // manchester start delimiter
    ST_DATA = 4'h8 // character bits
  } urfe_state_e;

endpackage : urfe_pkg

// [urfe_hold_reg.sv]
// receive holding register with ready and overrun flags
module urfe_hold_reg
  import urfe_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic write_in, // one-cycle: character complete
  input wire logic [CHAR_W-1:0] char_in,
  input wire logic sync_in,
  input wire logic read_in, // software took the character
  input wire logic clear_status_in, // reset-status command
  output logic [CHAR_W-1:0] char_out,
  output logic sync_out,
  output logic ready_out,
  output logic overrun_out
);

  logic [CHAR_W-1:0] char_q; // held character
  logic sync_q; // command/data tag of held character
  logic ready_q;
  logic overrun_q;

  // ----------------------------------------------------------------
  // storage: a new character always overwrites the old one
  // ----------------------------------------------------------------
  // RULE21 newest character wins
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      char_q <= '0;
      sync_q <= 1'b0;
    end else if (write_in) begin
      char_q <= char_in;
      sync_q <= sync_in;
    end
  end

  // ready: a write in the same cycle as a read keeps it set
  // RULE21 ready flag
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= write_in | (ready_q & ~read_in);
    end
  end

  // overrun: set beats clear, so no lost event
  // RULE21 overrun detection
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= (write_in & ready_q) | (overrun_q & ~clear_status_in);
    end
  end

  assign char_out = char_q;
  assign sync_out = sync_q;
  assign ready_out = ready_q;
  assign overrun_out = overrun_q;

  // RULE21 overrun check
  property p_overrun;
    @(posedge core_clk_in) disable iff (rst_in)
    (write_in && ready_q) |=> (overrun_q && ready_q);
  endproperty
  a_overrun: assert property (p_overrun) // RULE21
    else $error("overrun not raised on write over full holding reg");

  // RULE21 ready and data
  property p_ready;
    @(posedge core_clk_in) disable iff (rst_in)
    write_in |=> (ready_q && char_q == $past(char_in));
  endproperty
  a_ready: assert property (p_ready) // RULE21
    else $error("ready or character missing after write");

endmodule : urfe_hold_reg

// [urfe_receiver.sv]
// serial receive front end: async, manchester and synchronous receiver
// How it works
// RULE1: async oversamples 16x or 8x by select
// RULE2: start after half bit low, then bits
// RULE3: 16x: start at eighth low, bit/16
// RULE4: 8x: start at fourth low, bit/8
// RULE5: length, nine-bit, order, parity shared with transmitter
// RULE6: only one stop bit checked
// RULE7: hunt next start right after stop
// RULE8: manchester mode decodes with preamble, delimiter
// RULE9: preamble length sets count; zero disables
// RULE10: polarity inverts stream; pattern field picks preamble
// RULE11: delimiter bit: one-bit zero or sync
// RULE12: manchester start after quarter bit low
// RULE13: sample quarters; mismatch resyncs at next edge
// RULE14: bit decided at three quarters
// RULE15: data only after preamble and delimiter
// RULE16: missing mid-cell transition sets sticky error
// RULE17: sync type stored beside received character
// RULE18: sender keeps delimiter consistent with idle level
// RULE19: sync mode: baud edge sampling, low starts
// RULE20: sync mode shares character format
// RULE21: holding register, ready flag, overrun on overwrite
// RULE22: parity mismatch sets sticky parity error
// RULE23: low stop bit sets sticky framing error
module urfe_receiver
  import urfe_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic rxd_in, // serial data line
  input wire logic sample_tick_in, // oversampling clock pulse
  input wire logic baud_clk_in, // baud clock for sync mode
  input wire logic sync_mode_in,
  input wire logic oversample_8x_in,
  input wire logic [1:0] char_length_field_in,
  input wire logic nine_bit_select_in,
  input wire logic msb_first_select_in,
  input wire logic [2:0] parity_type_field_in,
  input wire logic manchester_enable_in,
  input wire logic [3:0] rx_preamble_length_in,
  input wire logic rx_manchester_polarity_in,
  input wire logic [1:0] rx_preamble_pattern_in,
  input wire logic delimiter_type_select_in,
  input wire logic reset_status_command_in,
  input wire logic holding_read_in,
  output logic [CHAR_W-1:0] received_char_field_out,
  output logic received_sync_flag_out,
  output logic receive_ready_flag_out,
  output logic overrun_flag_out,
  output logic parity_error_flag_out,
  output logic framing_error_flag_out,
  output logic manchester_error_flag_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // RULE1 RULE4 ratio select
  function automatic logic [4:0] bit_ticks(input logic over8);
    bit_ticks = over8 ? OVS_8 : OVS_16;
  endfunction : bit_ticks

  // RULE5 data bit count
  function automatic logic [3:0] char_len(input logic nine,
                                          input logic [1:0] char_length_field);
    char_len = nine ? NINE_LEN : CHAR_BASE + {2'b00, char_length_field};
  endfunction : char_len

  function automatic logic par_used(input logic [2:0] mode);
    par_used = (mode[2:1] != PAR_NONE_HI);
  endfunction : par_used

  // RULE22 parity check per mode
  function automatic logic par_bad(input logic [2:0] mode,
                                   input logic ones, input logic pbit);
    case (mode)
      PAR_EVEN: par_bad = (pbit != ones);
      PAR_ODD: par_bad = (pbit == ones);
      PAR_SPACE: par_bad = pbit;
      PAR_MARK: par_bad = ~pbit;
      PAR_MD_DATA, PAR_MD_ADDR: par_bad = pbit; // address byte flagged
      default: par_bad = 1'b0;
    endcase
  endfunction : par_bad

  // RULE10 expected preamble cell value
  function automatic logic pre_bit(input logic [1:0] pp, input logic odd);
    case (pp)
      PP_ALL_ONE: pre_bit = 1'b1;
      PP_ALL_ZERO: pre_bit = 1'b0;
      PP_ONE_ZERO: pre_bit = ~odd;
      PP_ZERO_ONE: pre_bit = odd;
      default: pre_bit = 1'b0;
    endcase
  endfunction : pre_bit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  urfe_state_e st_q; // receiver state
  logic [4:0] cnt_q; // sampling tick counter
  logic half_q; // manchester: first half of cell taken
  logic h1_q; // manchester: first half-bit sample
  logic [3:0] pre_cnt_q; // preamble cells matched
  logic [5:0] sfd_q; // sync delimiter half-bit history
  logic [2:0] nh_q; // sync delimiter half-bits seen
  logic cmd_q; // delimiter was a command sync
  logic baud_prev_q; // last baud clock level
  logic [3:0] bit_idx_q; // position within the character
  logic [CHAR_W-1:0] data_q; // assembled data bits
  logic acc_q; // running xor of data bits
  logic pbit_q; // received parity bit
  logic parity_err_q;
  logic framing_err_q;
  logic man_err_q;

  logic man_w; // manchester decoding active
  logic line_w; // line after polarity
  logic tick_w; // sampling moment
  logic baud_rise_w;
  logic [4:0] full_w;
  logic [4:0] half_w;
  logic [4:0] quarter_w;
  logic cnt_end_w; // last tick of a bit or half bit
  logic start_ok_w; // low long enough to be a start
  logic pair_w; // manchester cell complete outside data
  logic bit_stb_w; // one character bit taken
  logic bit_val_w;
  logic viol_w; // manchester code violation
  logic last_w; // stop bit taken, character complete
  logic [3:0] len_w;
  logic [3:0] total_w;
  logic [5:0] sfd_next_w;

  // ----------------------------------------------------------------
  // sampling moments
  // ----------------------------------------------------------------
  // manchester needs the oversampler, so it is off in sync mode
  // RULE8 manchester select
  assign man_w = manchester_enable_in & ~sync_mode_in;
  // RULE10 polarity
  assign line_w = man_w ? (rxd_in ^ rx_manchester_polarity_in) : rxd_in;
  // RULE19 rising baud edge
  assign baud_rise_w = baud_clk_in & ~baud_prev_q;
  assign tick_w = sync_mode_in ? baud_rise_w : sample_tick_in;
  assign full_w = bit_ticks(oversample_8x_in);
  assign half_w = {1'b0, full_w[4:1]};
  assign quarter_w = {2'b00, full_w[4:2]};
  // RULE20 one format for all modes
  assign len_w = char_len(nine_bit_select_in, char_length_field_in);
  assign total_w = len_w + {3'b000, par_used(parity_type_field_in)};
  assign sfd_next_w = {sfd_q[4:0], line_w};

  // edge detect on the baud clock input
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      baud_prev_q <= 1'b0;
    end else begin
      baud_prev_q <= baud_clk_in;
    end
  end

  // bit and cell strobes
  always_comb begin
    // RULE3 sample each bit after a full count
    cnt_end_w = man_w ? (cnt_q == half_w - 5'h01)
                      : (cnt_q == full_w - 5'h01);
    // RULE2 half bit low confirms start
    // RULE12 quarter bit in manchester
    if (sync_mode_in) begin
      start_ok_w = 1'b1;
    end else if (man_w) begin
      start_ok_w = (cnt_q == quarter_w - 5'h01);
    end else begin
      start_ok_w = (cnt_q == half_w - 5'h01);
    end
    pair_w = tick_w & cnt_end_w & half_q;
    // RULE15 bits pass only in the data state
    bit_stb_w = 1'b0;
    if (st_q == ST_DATA && tick_w) begin
      if (sync_mode_in) begin
        bit_stb_w = 1'b1;
      end else if (man_w) begin
        bit_stb_w = cnt_end_w & half_q;
      end else begin
        bit_stb_w = cnt_end_w;
      end
    end
    // RULE14 value from the three-quarter sample
    bit_val_w = man_w ? ~line_w : line_w;
    // RULE16 no mid-cell transition
    viol_w = man_w & bit_stb_w & (h1_q == line_w);
    // RULE6 one stop bit after data and parity
    last_w = bit_stb_w & (bit_idx_q == total_w);
  end

  // ----------------------------------------------------------------
  // tick counter and half-bit sampler
  // ----------------------------------------------------------------
  // a high sample restarts the low count, rejecting short pulses
  // RULE13 half-bit sampling
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_q <= 5'h00;
      half_q <= 1'b0;
      h1_q <= 1'b0;
    end else if (st_q == ST_IDLE) begin
      if (tick_w) begin
        if (line_w) begin
          cnt_q <= 5'h00;
        end else if (start_ok_w) begin
          // start point is the first quarter sample, known low
          cnt_q <= 5'h00;
          half_q <= man_w;
          h1_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end else if (last_w) begin
      cnt_q <= 5'h00;
      half_q <= 1'b0;
    end else if (tick_w && !sync_mode_in) begin
      if (cnt_end_w) begin
        cnt_q <= 5'h00;
        half_q <= man_w & ~half_q;
        if (!half_q) begin
          h1_q <= line_w;
        end
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      pre_cnt_q <= 4'h0;
      sfd_q <= 6'h00;
      nh_q <= 3'h0;
      cmd_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tick_w && !line_w && start_ok_w) begin
            pre_cnt_q <= 4'h0;
            sfd_q <= 6'h00;
            nh_q <= 3'h1;
            cmd_q <= 1'b0;
            // RULE9 zero length skips the preamble
            if (man_w) begin
              st_q <= (rx_preamble_length_in != 4'h0) ? ST_PRE : ST_SFD;
            end else begin
              st_q <= ST_DATA;
            end
          end
        end
        ST_PRE: begin
          if (!man_w) begin
            st_q <= ST_IDLE;
          end else if (pair_w) begin
            // RULE13 match keeps timing, mismatch resyncs
            if (h1_q != line_w &&
                h1_q == pre_bit(rx_preamble_pattern_in, pre_cnt_q[0])) begin
              if (pre_cnt_q + 4'h1 == rx_preamble_length_in) begin
                st_q <= ST_SFD;
                sfd_q <= 6'h00;
                nh_q <= 3'h0;
              end else begin
                pre_cnt_q <= pre_cnt_q + 4'h1;
              end
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_SFD: begin
          if (!man_w) begin
            st_q <= ST_IDLE;
          end else if (delimiter_type_select_in) begin
            // RULE11 one-bit delimiter: encoded zero only
            if (pair_w) begin
              st_q <= (!h1_q && line_w) ? ST_DATA : ST_IDLE;
            end
          end else if (tick_w && cnt_end_w) begin
            sfd_q <= sfd_next_w;
            nh_q <= nh_q + 3'h1;
            // RULE17 command or data sync
            if (nh_q == SYNC_LAST_HALF) begin
              if (sfd_next_w == SYNC_CMD) begin
                st_q <= ST_DATA;
                cmd_q <= 1'b1;
              end else if (sfd_next_w == SYNC_DATA) begin
                st_q <= ST_DATA;
                cmd_q <= 1'b0;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
        end
        ST_DATA: begin
          // RULE7 hunt again right after the stop bit
          if (last_w) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // character assembly
  // ----------------------------------------------------------------
  // RULE5 bit order and length
  always_ff @(posedge core_clk_in) begin
    if (rst_in || st_q == ST_IDLE) begin
      bit_idx_q <= 4'h0;
      data_q <= '0;
      acc_q <= 1'b0;
      pbit_q <= 1'b0;
    end else if (bit_stb_w) begin
      bit_idx_q <= bit_idx_q + 4'h1;
      if (bit_idx_q < len_w) begin
        acc_q <= acc_q ^ bit_val_w;
        if (msb_first_select_in) begin
          data_q <= {data_q[CHAR_W-2:0], bit_val_w};
        end else begin
          data_q[bit_idx_q] <= bit_val_w;
        end
      end else if (bit_idx_q == len_w) begin
        pbit_q <= bit_val_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky error flags; a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      parity_err_q <= 1'b0;
      framing_err_q <= 1'b0;
      man_err_q <= 1'b0;
    end else begin
      // RULE22 parity error
      parity_err_q <= (last_w & par_used(parity_type_field_in) &
                       par_bad(parity_type_field_in, acc_q, pbit_q)) |
                      (parity_err_q & ~reset_status_command_in);
      // RULE23 low stop bit
      framing_err_q <= (last_w & ~bit_val_w) |
                       (framing_err_q & ~reset_status_command_in);
      // RULE16 manchester error
      man_err_q <= viol_w | (man_err_q & ~reset_status_command_in);
    end
  end

  // ----------------------------------------------------------------
  // holding register
  // ----------------------------------------------------------------
  // RULE21 completed character handed over
  urfe_hold_reg u_hold (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .write_in(last_w),
    .char_in(data_q),
    .sync_in(cmd_q),
    .read_in(holding_read_in),
    .clear_status_in(reset_status_command_in),
    .char_out(received_char_field_out),
    .sync_out(received_sync_flag_out),
    .ready_out(receive_ready_flag_out),
    .overrun_out(overrun_flag_out)
  );

  assign parity_error_flag_out = parity_err_q;
  assign framing_error_flag_out = framing_err_q;
  assign manchester_error_flag_out = man_err_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // RULE3 start at eighth low
  property p_start16;
    @(posedge core_clk_in) disable iff (rst_in)
    (st_q == ST_IDLE && !man_w && !sync_mode_in && !oversample_8x_in &&
     tick_w && !line_w && cnt_q == 5'h07) |=> (st_q == ST_DATA);
  endproperty
  a_start16: assert property (p_start16) // RULE3
    else $error("16x start not taken at eighth low sample");

  // RULE4 start at fourth low
  property p_start8;
    @(posedge core_clk_in) disable iff (rst_in)
    (st_q == ST_IDLE && !man_w && !sync_mode_in && oversample_8x_in &&
     tick_w && !line_w && cnt_q == 5'h03) |=> (st_q == ST_DATA);
  endproperty
  a_start8: assert property (p_start8) // RULE4
    else $error("8x start not taken at fourth low sample");

  // RULE3 bit spacing 16
  property p_space16;
    @(posedge core_clk_in) disable iff (rst_in)
    (bit_stb_w && !man_w && !sync_mode_in && !oversample_8x_in)
      |-> (cnt_q == 5'h0f);
  endproperty
  a_space16: assert property (p_space16) // RULE3
    else $error("16x bit sampled off its sixteenth tick");

  // RULE4 bit spacing 8
  property p_space8;
    @(posedge core_clk_in) disable iff (rst_in)
    (bit_stb_w && !man_w && !sync_mode_in && oversample_8x_in)
      |-> (cnt_q == 5'h07);
  endproperty
  a_space8: assert property (p_space8) // RULE4
    else $error("8x bit sampled off its eighth tick");

  // RULE19 low on baud edge starts
  property p_sync_start;
    @(posedge core_clk_in) disable iff (rst_in)
    (st_q == ST_IDLE && sync_mode_in && baud_rise_w && !rxd_in)
      |=> (st_q == ST_DATA);
  endproperty
  a_sync_start: assert property (p_sync_start) // RULE19
    else $error("sync mode start missed");

  // RULE7 back to hunting
  property p_stop_idle;
    @(posedge core_clk_in) disable iff (rst_in)
    last_w |=> (st_q == ST_IDLE && receive_ready_flag_out);
  endproperty
  a_stop_idle: assert property (p_stop_idle) // RULE7
    else $error("receiver not hunting after stop bit");

  // RULE11 one-bit delimiter must be zero
  property p_delimiter_type_select;
    @(posedge core_clk_in) disable iff (rst_in)
    (st_q == ST_SFD && man_w && delimiter_type_select_in && pair_w && h1_q)
      |=> (st_q == ST_IDLE);
  endproperty
  a_delimiter_type_select: assert property (p_delimiter_type_select) // RULE11
    else $error("encoded one accepted as start delimiter");

  // RULE16 violation sets flag
  property p_manchester_error_flag;
    @(posedge core_clk_in) disable iff (rst_in)
    viol_w |=> manchester_error_flag_out;
  endproperty
  a_manchester_error_flag: assert property (p_manchester_error_flag) // RULE16
    else $error("manchester violation not flagged");

  // RULE22 parity error sticks
  property p_par_hold;
    @(posedge core_clk_in) disable iff (rst_in)
    (parity_err_q && !reset_status_command_in) |=> parity_err_q;
  endproperty
  a_par_hold: assert property (p_par_hold) // RULE22
    else $error("parity error dropped without reset-status");

  // RULE23 framing error
  property p_frame;
    @(posedge core_clk_in) disable iff (rst_in)
    (last_w && !bit_val_w) |=> framing_error_flag_out;
  endproperty
  a_frame: assert property (p_frame) // RULE23
    else $error("low stop bit not flagged");

endmodule : urfe_receiver

// [urfe_tx_model.sv]
// behavioural remote serial sender feeding the receive front end
module urfe_tx_model (
  input wire logic core_clk_in,
  output logic rxd_out,
  output logic sample_tick_out,
  output logic baud_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line high; tick pulses every second core clock
  initial begin
    rxd_out = 1'b1;
    sample_tick_out = 1'b0;
    baud_clk_out = 1'b0;
    forever @(posedge core_clk_in) #1 sample_tick_out = ~sample_tick_out;
  end

  // first bit is fr[0]; last bit cut short after its mid point,
  // so a low stop cannot fake a fresh start
  task automatic send(input logic [15:0] fr, input int n, input int ovs);
    @(posedge core_clk_in);
    for (int i = 0; i < n; i++) begin
      #1 rxd_out = fr[i];
      repeat (i == n - 1 ? ovs / 2 + 1 : ovs)
        @(posedge core_clk_in iff sample_tick_out);
    end
    #1 rxd_out = 1'b1;
  endtask : send

  // one bit per baud rising edge; baud stands low outside frames
  task automatic send_sync(input logic [15:0] fr, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_in) #1 baud_clk_out = 1'b0;
      rxd_out = fr[i];
      repeat (2) @(posedge core_clk_in);
      #1 baud_clk_out = 1'b1;
      @(posedge core_clk_in);
    end
    @(posedge core_clk_in) #1 rxd_out = 1'b1;
    baud_clk_out = 1'b0;
  endtask : send_sync
endmodule : urfe_tx_model

// [tb_top.sv]
// self-checking bench for the serial receive front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, rst_in = 1, rxd_in, sample_tick_in, baud_clk_in;
  logic sync_mode_in = 0, oversample_8x_in = 0, nine_bit_select_in = 0;
  logic msb_first_select_in = 0, manchester_enable_in = 0;
  logic rx_manchester_polarity_in = 0, delimiter_type_select_in = 1;
  logic reset_status_command_in = 0, holding_read_in = 0;
  logic [1:0] char_length_field_in = 2'h3, rx_preamble_pattern_in = 2'h0;
  logic [2:0] parity_type_field_in = 3'h0;
  logic [3:0] rx_preamble_length_in = 4'h0;
  logic [8:0] received_char_field_out;
  logic received_sync_flag_out, receive_ready_flag_out, overrun_flag_out;
  logic parity_error_flag_out, framing_error_flag_out;
  logic manchester_error_flag_out;
  int n_mismatch = 0, n_compared = 0;

  urfe_receiver dut (.*);
  urfe_tx_model far (.core_clk_in, .rxd_out(rxd_in),
    .sample_tick_out(sample_tick_in), .baud_clk_out(baud_clk_in));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // ready, overrun, parity, framing, manchester, sync
  function automatic logic [8:0] flags();
    return {3'h0, receive_ready_flag_out, overrun_flag_out,
      parity_error_flag_out, framing_error_flag_out,
      manchester_error_flag_out, received_sync_flag_out};
  endfunction : flags

  // read and reset-status together, then expect all flags low
  task automatic clr();
    @(posedge core_clk_in) #1 reset_status_command_in = 1;
    holding_read_in = 1;
    @(posedge core_clk_in) #1 reset_status_command_in = 0;
    holding_read_in = 0;
    @(posedge core_clk_in) #1;
    chk(flags(), 9'h000);
  endtask : clr

  task automatic t_async16();
    chk(flags(), 9'h000);
    far.send(16'h054A, 11, 16);
    repeat (2) @(posedge core_clk_in);
    chk(received_char_field_out, 9'h0A5);
    chk(flags(), 9'h020);
    clr();
    $display("async 16x done");
  endtask : t_async16

  // msb-first 7 bit odd, bad parity then a second char unread
  task automatic t_async8();
    oversample_8x_in = 1;
    char_length_field_in = 2'h2;
    msb_first_select_in = 1;
    parity_type_field_in = 3'h1;
    far.send(16'h03D0, 10, 8);
    far.send(16'h03AA, 10, 8);
    repeat (2) @(posedge core_clk_in);
    chk(received_char_field_out, 9'h055);
    chk(flags(), 9'h038);
    clr();
    $display("async 8x done");
  endtask : t_async8

  task automatic t_frame();
    oversample_8x_in = 0;
    char_length_field_in = 2'h0;
    msb_first_select_in = 0;
    parity_type_field_in = 3'h4;
    far.send(16'h0026, 7, 16);
    repeat (2) @(posedge core_clk_in);
    chk(received_char_field_out, 9'h013);
    chk(flags(), 9'h024);
    clr();
    $display("framing done");
  endtask : t_frame

  // manchester, one-bit delimiter, no preamble; each fr bit a half
  // bit of 8 ticks; fourth data cell lacks its mid-cell transition
  task automatic t_man();
    manchester_enable_in = 1;
    far.send(16'h1766, 14, 8); // low-high delimiter off idle high
    repeat (2) @(posedge core_clk_in);
    chk(received_char_field_out, 9'h015);
    chk(flags(), 9'h022);
    clr();
    manchester_enable_in = 0;
    $display("manchester done");
  endtask : t_man

  task automatic t_sync();
    sync_mode_in = 1;
    nine_bit_select_in = 1;
    far.send_sync(16'h0786, 11);
    repeat (2) @(posedge core_clk_in);
    chk(received_char_field_out, 9'h1C3);
    chk(flags(), 9'h020);
    $display("sync done");
  endtask : t_sync

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // 40 ns clock
  initial forever #20 core_clk_in = ~core_clk_in;

  // main sequence after 20 reset cycles
  initial begin
    repeat (20) @(posedge core_clk_in);
    #1 rst_in = 0;
    t_async16();
    t_async8();
    t_frame();
    t_man();
    t_sync();
    results();
  end

  // watchdog well beyond the roughly 1200 cycles needed
  initial begin
    #2_000_000;
    n_mismatch++;
    results();
  end
endmodule : tb_top
